// file: hdl/pcs_defs.svh
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

// Register select codes
`define PCS_SEL_FUNC       4'h2
`define PCS_SEL_CTL2       4'h3
`define PCS_SEL_STAT1      4'h4
`define PCS_SEL_STAT2      4'h5
`define PCS_SEL_DISC_LO    4'h6
`define PCS_SEL_DISC_HI    4'h7

// Control two field positions
`define PCS_CTL2_DIS_BIT   4
`define PCS_CTL2_START_BIT 3
`define PCS_CTL2_ABORT_BIT 2

// Status one field positions
`define PCS_ST1_FAIL_BIT   7
`define PCS_ST1_DONE_BIT   6
`define PCS_ST1_CLASS_LSB  3
`define PCS_ST1_FAULT_LSB  0

// Status two field positions
`define PCS_ST2_WDOG_BIT   4
`define PCS_ST2_BUSY_BIT   3
`define PCS_ST2_STATE_LSB  0

// Discovery upper register complete flag
`define PCS_DISC_DONE_BIT  7

// Function codes seen on the function register
`define PCS_FN_OFF         4'h0
`define PCS_FN_DISC1       4'h1
`define PCS_FN_DISC2       4'h2

// Reset values
`define PCS_RST_BYTE       8'h00
`define PCS_RST_RESULT     15'h0000

`endif

// file: hdl/pcs_pkg.sv
package pcs_pkg;

  // Fault cause codes
  typedef enum logic [2:0] {
    PCS_FLT_NONE    = 3'h0,
    PCS_FLT_SUPPLY  = 3'h1,
    PCS_FLT_THERMAL = 3'h2,
    PCS_FLT_OVLD    = 3'h3,
    PCS_FLT_DISC    = 3'h4
  } pcs_fault_t;

  // Function state codes
  typedef enum logic [2:0] {
    PCS_FS_DISABLED = 3'h0,
    PCS_FS_SEARCH   = 3'h1,
    PCS_FS_POWER    = 3'h2,
    PCS_FS_FAULT    = 3'h3,
    PCS_FS_TEST     = 3'h4,
    PCS_FS_OTHER    = 3'h5
  } pcs_fstate_t;

  typedef logic [2:0] pcs_class_t;

endpackage : pcs_pkg

// file: hdl/pcs_acc_if.sv
`timescale 1ns/1ns
// Decoded register access strobes between front end and register bank
interface pcs_acc_if #(parameter int NPORT = 4);
  logic [NPORT-1:0] wr_func;
  logic [NPORT-1:0] wr_ctl2;
  logic [7:0]       wdata;
  logic             rd;
  logic [1:0]       rd_port;
  logic [3:0]       rd_sel;
  modport src (output wr_func, wr_ctl2, wdata, rd, rd_port, rd_sel);
  modport dst (input  wr_func, wr_ctl2, wdata, rd, rd_port, rd_sel);
endinterface : pcs_acc_if

// file: hdl/pcs_acc.sv
`timescale 1ns/1ns
`include "pcs_defs.svh"
// Registers the access port and decodes per-port write strobes
module pcs_acc #(
  parameter int NPORT = 4
) (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic       acc_wr_in,
  input  wire logic       acc_rd_in,
  input  wire logic [1:0] acc_port_in,
  input  wire logic [3:0] acc_sel_in,
  input  wire logic [7:0] acc_wdata_in,
  pcs_acc_if.src          acc
);

  logic [NPORT-1:0] wr_func_ff, nxt_wr_func;
  logic [NPORT-1:0] wr_ctl2_ff, nxt_wr_ctl2;
  logic [7:0]       wdata_ff,   nxt_wdata;
  logic             rd_ff,      nxt_rd;
  logic [1:0]       port_ff,    nxt_port;
  logic [3:0]       sel_ff,     nxt_sel;

  // Per-port write decode, one strobe per addressed port
  always_comb begin
    nxt_wdata   = acc_wdata_in;
    nxt_rd      = acc_rd_in;
    nxt_port    = acc_port_in;
    nxt_sel     = acc_sel_in;
    nxt_wr_func = '0;
    nxt_wr_ctl2 = '0;
    for (int p = 0; p < NPORT; p++) begin
      if (acc_wr_in && (acc_port_in == p[1:0])) begin
        nxt_wr_func[p] = (acc_sel_in == `PCS_SEL_FUNC);
        nxt_wr_ctl2[p] = (acc_sel_in == `PCS_SEL_CTL2);
      end
    end
  end

  // Access pipeline stage
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_func_ff <= '0;
      wr_ctl2_ff <= '0;
      wdata_ff   <= 8'h00;
      rd_ff      <= 1'b0;
      port_ff    <= 2'h0;
      sel_ff     <= 4'h0;
    end else begin
      wr_func_ff <= nxt_wr_func;
      wr_ctl2_ff <= nxt_wr_ctl2;
      wdata_ff   <= nxt_wdata;
      rd_ff      <= nxt_rd;
      port_ff    <= nxt_port;
      sel_ff     <= nxt_sel;
    end
  end

  assign acc.wr_func = wr_func_ff;
  assign acc.wr_ctl2 = wr_ctl2_ff;
  assign acc.wdata   = wdata_ff;
  assign acc.rd      = rd_ff;
  assign acc.rd_port = port_ff;
  assign acc.rd_sel  = sel_ff;

endmodule : pcs_acc

// file: hdl/pcs_regs.sv
`timescale 1ns/1ns
`include "pcs_defs.svh"
// Function
// - each port owns a control-two register; a write touches only that port
// - control-two bit 4 set disables the port, clear leaves it normal
// - control-two bit 3 starts a conversion unless bit 2 is set in the same write, and clears itself
// - control-two bit 2 set aborts the running conversion
// - status one at code 0100 and status two at 0101, read only
// - status one bit 7 reads 1 when discovery failed
// - status one bit 6 set on function done, cleared by function write
// - status one bits 5..3 report power class 0 to 4
// - status one bits 2..0 report fault cause code
// - status two bit 3 conversion active, bit 4 watchdog active
// - status two bits 2..0 report disabled, searching, power delivery
// - further states fault, test, other fault; 110 and 111 never produced
// - code 0110 holds discovery result bits 7..0
// - code 0111 holds result bits 14..8 in bits 6..0
// - upper register bit 7 cleared when either discovery phase starts
// - upper register bit 7 set when the discovery conversion finishes
// - function code 0000 powers the port down and resets its functions
module pcs_regs #(
  parameter int NPORT = 4
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  soft_reset_in,
  input  wire logic                  acc_wr_in,
  input  wire logic                  acc_rd_in,
  input  wire logic [1:0]            acc_port_in,
  input  wire logic [3:0]            acc_sel_in,
  input  wire logic [7:0]            acc_wdata_in,
  output logic      [7:0]            acc_rdata_out,
  output logic                       acc_rvalid_out,
  input  wire logic [NPORT-1:0]      disc_fail_in,
  input  wire logic [NPORT-1:0]      func_done_in,
  input  wire logic [NPORT-1:0]      class_load_in,
  input  wire logic [NPORT-1:0][2:0] class_in,
  input  wire logic [NPORT-1:0]      fault_load_in,
  input  wire logic [NPORT-1:0][2:0] fault_in,
  input  wire logic [NPORT-1:0]      watchdog_in,
  input  wire logic [NPORT-1:0][2:0] func_state_in,
  input  wire logic [NPORT-1:0]      adc_done_in,
  input  wire logic [NPORT-1:0][14:0] adc_result_in,
  output logic      [NPORT-1:0]      port_disable_out,
  output logic      [NPORT-1:0]      adc_start_out,
  output logic      [NPORT-1:0]      adc_abort_out
);

  pcs_acc_if #(.NPORT(NPORT)) acc ();

  // Access front end
  pcs_acc #(.NPORT(NPORT)) u_acc (
    .sys_clk_in   (sys_clk_in),
    .rst_in       (rst_in),
    .acc_wr_in    (acc_wr_in),
    .acc_rd_in    (acc_rd_in),
    .acc_port_in  (acc_port_in),
    .acc_sel_in   (acc_sel_in),
    .acc_wdata_in (acc_wdata_in),
    .acc          (acc.src)
  );

  // Maps undefined state codes onto the other-fault code
  function automatic logic [2:0] fix_state(input logic [2:0] s);
    if (s > pcs_pkg::PCS_FS_OTHER) begin
      fix_state = pcs_pkg::PCS_FS_OTHER;
    end else begin
      fix_state = s;
    end
  endfunction : fix_state

  // Maps out-of-range class or reserved fault codes to zero
  function automatic logic [2:0] fix_code(input logic [2:0] c, input logic [2:0] lim);
    if (c > lim) begin
      fix_code = 3'h0;
    end else begin
      fix_code = c;
    end
  endfunction : fix_code

  // Control two state
  logic [NPORT-1:0] dis_ff,   nxt_dis;
  logic [NPORT-1:0] start_ff, nxt_start;
  logic [NPORT-1:0] abort_ff, nxt_abort;

  // Status state
  logic [NPORT-1:0]       fail_ff,  nxt_fail;
  logic [NPORT-1:0]       done_ff,  nxt_done;
  logic [NPORT-1:0][2:0]  class_ff, nxt_class;
  logic [NPORT-1:0][2:0]  fault_ff, nxt_fault;
  logic [NPORT-1:0]       wdog_ff,  nxt_wdog;
  logic [NPORT-1:0]       busy_ff,  nxt_busy;
  logic [NPORT-1:0][2:0]  state_ff, nxt_state;

  // Discovery result state
  logic [NPORT-1:0]       disc_act_ff, nxt_disc_act;
  logic [NPORT-1:0]       disc_cmp_ff, nxt_disc_cmp;
  logic [NPORT-1:0][14:0] disc_res_ff, nxt_disc_res;

  // Read answer state
  logic [7:0] rdata_ff,  nxt_rdata;
  logic       rvalid_ff, nxt_rvalid;

  // Per-port control and status next values
  always_comb begin
    nxt_dis      = dis_ff;
    nxt_start    = '0;
    nxt_abort    = abort_ff;
    nxt_fail     = fail_ff;
    nxt_done     = done_ff;
    nxt_class    = class_ff;
    nxt_fault    = fault_ff;
    nxt_wdog     = watchdog_in;
    nxt_busy     = busy_ff;
    nxt_state    = state_ff;
    nxt_disc_act = disc_act_ff;
    nxt_disc_cmp = disc_cmp_ff;
    nxt_disc_res = disc_res_ff;
    for (int p = 0; p < NPORT; p++) begin
      // Discovery failure level
      nxt_fail[p]  = disc_fail_in[p];
      // Function state, undefined codes never shown
      nxt_state[p] = fix_state(func_state_in[p]);
      // Class and fault captured on their load strobes
      if (class_load_in[p]) begin
        nxt_class[p] = fix_code(class_in[p], 3'h4);
      end
      if (fault_load_in[p]) begin
        nxt_fault[p] = fix_code(fault_in[p], pcs_pkg::PCS_FLT_DISC);
      end
      // Control two write, bits 4..2 only
      if (acc.wr_ctl2[p]) begin
        nxt_dis[p]   = acc.wdata[`PCS_CTL2_DIS_BIT];
        nxt_abort[p] = acc.wdata[`PCS_CTL2_ABORT_BIT];
        nxt_start[p] = acc.wdata[`PCS_CTL2_START_BIT] &
                       ~acc.wdata[`PCS_CTL2_ABORT_BIT];
      end
      // Conversion busy tracking
      if (start_ff[p]) begin
        nxt_busy[p] = 1'b1;
      end else if (adc_done_in[p] || abort_ff[p]) begin
        nxt_busy[p] = 1'b0;
      end
      // Function write clears done; a same-cycle done event wins
      if (acc.wr_func[p]) begin
        nxt_done[p] = 1'b0;
      end
      if (func_done_in[p]) begin
        nxt_done[p] = 1'b1;
      end
      // Discovery conversion completes the result
      if (disc_act_ff[p] && adc_done_in[p]) begin
        nxt_disc_res[p] = adc_result_in[p];
        nxt_disc_cmp[p] = 1'b1;
        nxt_disc_act[p] = 1'b0;
      end
      // Discovery phase start clears the complete flag
      if (acc.wr_func[p] && ((acc.wdata[3:0] == `PCS_FN_DISC1) ||
                             (acc.wdata[3:0] == `PCS_FN_DISC2))) begin
        nxt_disc_cmp[p] = 1'b0;
        nxt_disc_act[p] = 1'b1;
      end
      // Disable function resets the port
      if (acc.wr_func[p] && (acc.wdata[3:0] == `PCS_FN_OFF)) begin
        nxt_dis[p]      = 1'b0;
        nxt_abort[p]    = 1'b0;
        nxt_start[p]    = 1'b0;
        nxt_busy[p]     = 1'b0;
        nxt_class[p]    = 3'h0;
        nxt_fault[p]    = 3'h0;
        nxt_disc_act[p] = 1'b0;
        nxt_disc_cmp[p] = 1'b0;
        nxt_disc_res[p] = `PCS_RST_RESULT;
      end
    end
  end

  // Read multiplexer, unused bits forced to zero
  always_comb begin
    logic [1:0] rp;
    rp         = acc.rd_port;
    nxt_rvalid = acc.rd;
    nxt_rdata  = `PCS_RST_BYTE;
    if (acc.rd) begin
      case (acc.rd_sel)
        `PCS_SEL_STAT1: begin
          nxt_rdata[`PCS_ST1_FAIL_BIT]                    = fail_ff[rp];
          nxt_rdata[`PCS_ST1_DONE_BIT]                    = done_ff[rp];
          nxt_rdata[`PCS_ST1_CLASS_LSB+2:`PCS_ST1_CLASS_LSB] = class_ff[rp];
          nxt_rdata[`PCS_ST1_FAULT_LSB+2:`PCS_ST1_FAULT_LSB] = fault_ff[rp];
        end
        `PCS_SEL_STAT2: begin
          nxt_rdata[`PCS_ST2_WDOG_BIT]                    = wdog_ff[rp];
          nxt_rdata[`PCS_ST2_BUSY_BIT]                    = busy_ff[rp];
          nxt_rdata[`PCS_ST2_STATE_LSB+2:`PCS_ST2_STATE_LSB] = state_ff[rp];
        end
        `PCS_SEL_DISC_LO: begin
          nxt_rdata = disc_res_ff[rp][7:0];
        end
        `PCS_SEL_DISC_HI: begin
          nxt_rdata[6:0] = disc_res_ff[rp][14:8];
          nxt_rdata[`PCS_DISC_DONE_BIT] = disc_cmp_ff[rp];
        end
        default: begin
          nxt_rdata = `PCS_RST_BYTE;
        end
      endcase
    end
  end

  // State registers, cleared by power-on and software reset
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || soft_reset_in) begin
      dis_ff      <= '0;
      start_ff    <= '0;
      abort_ff    <= '0;
      fail_ff     <= '0;
      done_ff     <= '0;
      class_ff    <= '0;
      fault_ff    <= '0;
      wdog_ff     <= '0;
      busy_ff     <= '0;
      state_ff    <= '0;
      disc_act_ff <= '0;
      disc_cmp_ff <= '0;
      disc_res_ff <= '0;
      rdata_ff    <= `PCS_RST_BYTE;
      rvalid_ff   <= 1'b0;
    end else begin
      dis_ff      <= nxt_dis;
      start_ff    <= nxt_start;
      abort_ff    <= nxt_abort;
      fail_ff     <= nxt_fail;
      done_ff     <= nxt_done;
      class_ff    <= nxt_class;
      fault_ff    <= nxt_fault;
      wdog_ff     <= nxt_wdog;
      busy_ff     <= nxt_busy;
      state_ff    <= nxt_state;
      disc_act_ff <= nxt_disc_act;
      disc_cmp_ff <= nxt_disc_cmp;
      disc_res_ff <= nxt_disc_res;
      rdata_ff    <= nxt_rdata;
      rvalid_ff   <= nxt_rvalid;
    end
  end

  // Outputs straight from flip-flops
  assign port_disable_out = dis_ff;
  assign adc_start_out    = start_ff;
  assign adc_abort_out    = abort_ff;
  assign acc_rdata_out    = rdata_ff;
  assign acc_rvalid_out   = rvalid_ff;

endmodule : pcs_regs

// file: dv/pcs_regs_props.sv
`timescale 1ns/1ns
// Port timing checks of the register bank
module pcs_regs_props #(
  parameter int NPORT = 4
) (
  input wire logic             sys_clk_in,
  input wire logic             rst_in,
  input wire logic             soft_reset_in,
  input wire logic             acc_wr_in,
  input wire logic             acc_rd_in,
  input wire logic [1:0]       acc_port_in,
  input wire logic [3:0]       acc_sel_in,
  input wire logic [7:0]       acc_wdata_in,
  input wire logic [7:0]       acc_rdata_out,
  input wire logic             acc_rvalid_out,
  input wire logic [NPORT-1:0] port_disable_out,
  input wire logic [NPORT-1:0] adc_start_out,
  input wire logic [NPORT-1:0] adc_abort_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in || soft_reset_in);
  // Write steps on control two
  sequence s_ctl2_wr;
    acc_wr_in && acc_sel_in == 4'h3;
  endsequence
  sequence s_start_wr;
    s_ctl2_wr ##0 acc_wdata_in[3:2] == 2'b10;
  endsequence
  sequence s_both_wr;
    s_ctl2_wr ##0 acc_wdata_in[3:2] == 2'b11;
  endsequence
  property p_lvl(logic [NPORT-1:0] q, int b);
    s_ctl2_wr |-> ##2 q[$past(acc_port_in, 2)] == $past(acc_wdata_in[b], 2);
  endproperty
  disable_lvl_a: assert property (p_lvl(port_disable_out, 4))
    else $error("port disable does not follow write");
  abort_lvl_a: assert property (p_lvl(adc_abort_out, 2))
    else $error("abort does not follow write");
  start_pulse_a: assert property (s_start_wr |->
    ##2 adc_start_out == NPORT'(1) << $past(acc_port_in, 2))
    else $error("start pulse missing or on wrong port");
  start_block_a: assert property (s_both_wr |->
    ##2 !adc_start_out[$past(acc_port_in, 2)])
    else $error("start pulse despite abort in same write");
  start_cause_a: assert property (|adc_start_out |->
    $past(acc_wr_in, 2) && $past(acc_wdata_in[3], 2))
    else $error("start pulse without start write");
  read_answer_a: assert property (acc_rd_in |-> ##2 acc_rvalid_out)
    else $error("read not answered after two cycles");
  idle_data_a: assert property (!acc_rvalid_out |-> acc_rdata_out == 8'h00)
    else $error("read data not zero while idle");
  wo_read_a: assert property (acc_rd_in && acc_sel_in < 4'h4 |->
    ##2 acc_rdata_out == 8'h00)
    else $error("write-only select read nonzero");
  stat1_codes_a: assert property (acc_rvalid_out && $past(acc_sel_in, 2) == 4'h4 |->
    acc_rdata_out[5:3] <= 3'h4 && acc_rdata_out[2:0] <= 3'h4) else $error("bad class or fault");
  stat2_codes_a: assert property (acc_rvalid_out && $past(acc_sel_in, 2) == 4'h5 |->
    acc_rdata_out[7:5] == 3'h0 && acc_rdata_out[2:0] <= 3'h5) else $error("bad state code");
endmodule : pcs_regs_props

bind pcs_regs pcs_regs_props #(.NPORT(NPORT)) i_props (
  .sys_clk_in, .rst_in, .soft_reset_in, .acc_wr_in, .acc_rd_in, .acc_port_in,
  .acc_sel_in, .acc_wdata_in, .acc_rdata_out, .acc_rvalid_out, .port_disable_out,
  .adc_start_out, .adc_abort_out
);

// file: dv/pcs_eng_model.sv
`timescale 1ns/1ns
// Conversion engine stand-in, finishes a started conversion after DELAY cycles
module pcs_eng_model #(
  parameter logic [14:0] RESULT = 15'h5A3C,
  parameter int          DELAY  = 6
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  adc_start_in,
  input  wire logic [3:0]  adc_abort_in,
  output logic [3:0]       adc_done_out,
  output logic [3:0][14:0] adc_result_out
);
  int cnt_ff [4];
  // Per-port countdown; abort drops the conversion, result invalid outside done
  always @(posedge sys_clk_in) begin
    for (int p = 0; p < 4; p++) begin
      adc_done_out[p] <= 1'b0;
      adc_result_out[p] <= ~RESULT;
      if (rst_in || adc_abort_in[p]) begin
        cnt_ff[p] <= 0;
      end else if (adc_start_in[p]) begin
        cnt_ff[p] <= DELAY;
      end else if (cnt_ff[p] == 1) begin
        cnt_ff[p] <= 0;
        adc_done_out[p] <= 1'b1;
        adc_result_out[p] <= RESULT;
      end else if (cnt_ff[p] > 1) begin
        cnt_ff[p] <= cnt_ff[p] - 1;
      end
    end
  end
endmodule : pcs_eng_model

// file: dv/poe_port_control_status_regs_tb.sv
`timescale 1ns/1ns
// Register access sequences against expected values
module poe_port_control_status_regs_tb;
  localparam logic [14:0] RES = 15'h5A3C;
  localparam int          DLY = 6;
  logic             sys_clk_in     = 1'b0;
  logic             rst_in         = 1'b1;
  logic             soft_reset_in  = 1'b0;
  logic             acc_wr_in      = 1'b0;
  logic             acc_rd_in      = 1'b0;
  logic [1:0]       acc_port_in    = 2'h0;
  logic [3:0]       acc_sel_in     = 4'h0;
  logic [7:0]       acc_wdata_in   = 8'h00;
  logic [3:0]       disc_fail_in   = 4'h0;
  logic [3:0]       func_done_in   = 4'h0;
  logic [3:0]       class_load_in  = 4'h0;
  logic [3:0][2:0]  class_in       = 12'h000;
  logic [3:0]       fault_load_in  = 4'h0;
  logic [3:0][2:0]  fault_in       = 12'h000;
  logic [3:0]       watchdog_in    = 4'h0;
  logic [3:0][2:0]  func_state_in  = 12'h000;
  logic [3:0]       adc_done_in;
  logic [3:0][14:0] adc_result_in;
  logic [7:0]       acc_rdata_out;
  logic             acc_rvalid_out;
  logic [3:0]       port_disable_out;
  logic [3:0]       adc_start_out;
  logic [3:0]       adc_abort_out;
  int               miscompares    = 0;
  int               check_count    = 0;

  // Clock, 10 ns period
  always #5 sys_clk_in = ~sys_clk_in;

  pcs_regs #(.NPORT(4)) i_dut (
    .sys_clk_in, .rst_in, .soft_reset_in, .acc_wr_in, .acc_rd_in, .acc_port_in,
    .acc_sel_in, .acc_wdata_in, .acc_rdata_out, .acc_rvalid_out, .disc_fail_in,
    .func_done_in, .class_load_in, .class_in, .fault_load_in, .fault_in, .watchdog_in,
    .func_state_in, .adc_done_in, .adc_result_in, .port_disable_out, .adc_start_out,
    .adc_abort_out
  );
  pcs_eng_model #(.RESULT(RES), .DELAY(DLY)) i_eng (
    .sys_clk_in, .rst_in, .adc_start_in(adc_start_out), .adc_abort_in(adc_abort_out),
    .adc_done_out(adc_done_in), .adc_result_out(adc_result_in)
  );

  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Step to just after the next rising edge
  task automatic tick();
    @(posedge sys_clk_in);
    #1;
  endtask : tick

  // Host write, returns once the effect is visible
  task automatic wr(input logic [1:0] p, input logic [3:0] s, input logic [7:0] d);
    acc_port_in = p;
    acc_sel_in = s;
    acc_wdata_in = d;
    acc_wr_in = 1'b1;
    tick();
    acc_wr_in = 1'b0;
    tick();
    tick();
  endtask : wr

  // Host read with bounded wait for the answer
  task automatic rd(input logic [1:0] p, input logic [3:0] s, input logic [7:0] exp);
    int n;
    acc_port_in = p;
    acc_sel_in = s;
    acc_rd_in = 1'b1;
    tick();
    acc_rd_in = 1'b0;
    for (n = 0; n < 4 && acc_rvalid_out !== 1'b1; n++) tick();
    if (n == 4) begin
      miscompares++;
      $display("CHECK FAILED at %0t: no read answer", $time);
      complete_run();
    end
    check(acc_rdata_out, exp, "read");
  endtask : rd

  // Main sequence
  initial begin
    repeat (20) @(posedge sys_clk_in);
    #1;
    rst_in = 1'b0;
    for (int p = 0; p < 4; p++) begin
      for (int s = 2; s < 9; s++) rd(2'(p), 4'(s), 8'h00);
    end
    $display("Section reset values finished");
    wr(2'h1, 4'h3, 8'h10);
    check({4'h0, port_disable_out}, 8'h02, "disable");
    wr(2'h1, 4'h3, 8'hE3);
    check({4'h0, port_disable_out | adc_abort_out}, 8'h00, "unused bits");
    $display("Section control two finished");
    wr(2'h2, 4'h2, 8'h01);
    wr(2'h2, 4'h3, 8'h08);
    tick();
    rd(2'h2, 4'h5, 8'h08);
    repeat (DLY + 4) tick();
    rd(2'h2, 4'h5, 8'h00);
    rd(2'h2, 4'h6, RES[7:0]);
    rd(2'h2, 4'h7, {1'b1, RES[14:8]});
    wr(2'h2, 4'h2, 8'h02);
    rd(2'h2, 4'h7, {1'b0, RES[14:8]});
    $display("Section discovery finished");
    wr(2'h0, 4'h3, 8'h08);
    wr(2'h0, 4'h3, 8'h04);
    check({4'h0, adc_abort_out}, 8'h01, "abort");
    rd(2'h0, 4'h5, 8'h00);
    repeat (DLY + 4) tick();
    rd(2'h0, 4'h7, 8'h00);
    wr(2'h0, 4'h3, 8'h00);
    wr(2'h0, 4'h3, 8'h0C);
    check({4'h0, adc_abort_out}, 8'h01, "start with abort");
    rd(2'h0, 4'h5, 8'h00);
    wr(2'h0, 4'h3, 8'h00);
    $display("Section abort finished");
    disc_fail_in = 4'h8;
    for (int i = 0; i < 8; i++) begin
      class_in[3] = 3'(i);
      fault_in[3] = 3'(7 - i);
      class_load_in = 4'h8;
      fault_load_in = 4'h8;
      func_done_in = 4'h8;
      tick();
      class_load_in = 4'h0;
      fault_load_in = 4'h0;
      func_done_in = 4'h0;
      rd(2'h3, 4'h4, {2'b11, (i > 4) ? 3'h0 : 3'(i), (i < 3) ? 3'h0 : 3'(7 - i)});
    end
    disc_fail_in = 4'h0;
    wr(2'h3, 4'h2, 8'h05);
    rd(2'h3, 4'h4, 8'h00);
    $display("Section status one finished");
    watchdog_in = 4'h1;
    for (int s = 0; s < 8; s++) begin
      func_state_in[0] = 3'(s);
      tick();
      rd(2'h0, 4'h5, {3'h0, 2'b10, (s > 5) ? 3'h5 : 3'(s)});
    end
    $display("Section status two finished");
    wr(2'h1, 4'h3, 8'h14);
    wr(2'h1, 4'h2, 8'h00);
    check({4'h0, port_disable_out | adc_abort_out}, 8'h00, "function off");
    wr(2'h2, 4'h3, 8'h10);
    soft_reset_in = 1'b1;
    tick();
    soft_reset_in = 1'b0;
    check({4'h0, port_disable_out}, 8'h00, "soft reset");
    rd(2'h2, 4'h6, 8'h00);
    $display("Section power down finished");
    complete_run();
  end
endmodule : poe_port_control_status_regs_tb
